// ### hdl/bsr_defines.svh
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

// ==========================================================
// Instruction opcodes
`define BSR_IR_W 6
`define BSR_OP_EXTEST 6'h00
`define BSR_OP_SAMPLE 6'h01
`define BSR_OP_IDCODE 6'h02
`define BSR_OP_HIGHZ 6'h03
`define BSR_OP_CLAMP 6'h3E
`define BSR_OP_BYPASS 6'h3F

// ==========================================================
// Widths (cell counts, pin counts for bidirectional and management groups, ID bits)
`define BSR_RX_CELLS 64
`define BSR_STRAP_CELLS 18
`define BSR_TX_CELLS 32
`define BSR_BIDIR_PINS 20
`define BSR_MGMT_PINS 4
`define BSR_ID_W 32

// ==========================================================
// Reset and capture values
`define BSR_BYPASS_CAPTURE 1'h0
`define BSR_BYPASS_RESET 1'h0
`define BSR_TDO_RESET 1'h0
`define BSR_ID_DEFAULT 32'h0000_0001
`define BSR_MODE_W 3
`define BSR_MODE_RESET 3'h0

`endif

// ### hdl/bsr_pkg.sv
package bsr_pkg;

  // ==========================================================
  // Data register path picked by the current instruction
  typedef enum logic [1:0] {
    BSR_SEL_BYPASS,
    BSR_SEL_CHAIN,
    BSR_SEL_IDENT
  } bsr_dr_sel_t;

endpackage : bsr_pkg

// ### hdl/bsr_sync_if.sv
`timescale 1ns/1ps

interface bsr_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] async_d;
  logic [W-1:0] sync_q;

  modport src (output async_d);
  modport dst (input sync_q);
  modport syn (input async_d, output sync_q);
endinterface : bsr_sync_if

// ### hdl/bsr_sync.sv
`timescale 1ns/1ps

// ==========================================================
// Two-flop level synchroniser; first stage feeds only the second
module bsr_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Crossing signals
  bsr_sync_if.syn port
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bsr_sync_state_t;

  bsr_sync_state_t s_q;
  bsr_sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = port.async_d;
    s_d.stable = s_q.meta;
  end

  // No reset: pure data stages, settled within two edges of any source
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign port.sync_q = s_q.stable;

endmodule : bsr_sync

// ### hdl/bsr_top.sv
// Notes on behaviour
// - Bypass, boundary and identification registers sit in parallel, instruction picks one.
// - Boundary chain sits between test input and output for external-test or sample.
// - Entering external-test drives held output latches onto pins immediately.
// - Every transmit, enable and data cell has a latch updated on the falling test clock; receive and strap cells have none.
// - Input-only pins get observe cells that never drive pin or core.
// - Output enable cells are output cells whose value drives pad enables.
// - Each bidirectional pin uses one enable cell and one single-register capture cell.
// - Enable high without external-test: capture takes core-to-pad data.
// - Enable low or external-test: capture takes pad-to-core data.
// - Receive pins and straps observe, transmit pins control, bidirectional pins both.
// - Sixteen general I/O pins are bidirectional; clocks, mode straps, test pins uncelled.
// - Inputs sampled on rising test clock; test output changes on falling edge.
// - Test output stays disabled except while shifting data or instruction.
// - Six-bit opcodes: 000000 external-test, 000001 sample; both pick the chain.
// - Under external-test, Update-DR latches shifted values onto outputs and enables.
`timescale 1ns/1ps
`include "bsr_defines.svh"

module bsr_top #(
  parameter int RX_W = `BSR_RX_CELLS,
  parameter int STRAP_W = `BSR_STRAP_CELLS,
  parameter int TX_W = `BSR_TX_CELLS,
  parameter int BI_W = `BSR_BIDIR_PINS,
  // Arbitrary identification value, not tied to any real part
  parameter logic [`BSR_ID_W-1:0] ID_CODE = `BSR_ID_DEFAULT
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Test access port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Controller state strobes and current instruction (test clock domain)
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic shift_ir,
  input wire logic [`BSR_IR_W-1:0] ir_current,
  input wire logic ir_serial_out,
  // Receive pins and straps (observe only)
  input wire logic [RX_W-1:0] port_rx_pad,
  output logic [RX_W-1:0] core_rx,
  input wire logic [STRAP_W-1:0] strap_pad,
  output logic [STRAP_W-1:0] core_strap,
  // Transmit pins (control)
  input wire logic [TX_W-1:0] core_tx,
  output logic [TX_W-1:0] port_tx_pad,
  output logic [TX_W-1:0] port_tx_oe,
  // Bidirectional pins: [3:0] management bus, [19:4] general I/O
  input wire logic [BI_W-1:0] core_bidir_out,
  input wire logic [BI_W-1:0] core_bidir_oe,
  output logic [BI_W-1:0] core_bidir_in,
  input wire logic [BI_W-1:0] pad_bidir_in,
  output logic [BI_W-1:0] pad_bidir_out,
  output logic [BI_W-1:0] pad_bidir_oe,
  // Test mode seen by the core: {highz, clamp, extest}
  output logic [`BSR_MODE_W-1:0] core_test_mode
);

  // ==========================================================
  // Chain layout, bit 0 nearest the test output
  localparam int OBS_W = RX_W + STRAP_W;
  localparam int TX_LO = OBS_W;
  localparam int OE_LO = TX_LO + TX_W;
  localparam int DAT_LO = OE_LO + BI_W;
  localparam int CH_W = DAT_LO + BI_W;
  localparam int UPD_W = CH_W - OBS_W;
  localparam int SYN_W = RX_W + STRAP_W + TX_W + 3 * BI_W;

  // ==========================================================
  // Instruction decode
  function automatic bsr_pkg::bsr_dr_sel_t dr_select(input logic [`BSR_IR_W-1:0] op);
    bsr_pkg::bsr_dr_sel_t sel;
    sel = bsr_pkg::BSR_SEL_BYPASS;
    if (op == `BSR_OP_EXTEST || op == `BSR_OP_SAMPLE) begin
      sel = bsr_pkg::BSR_SEL_CHAIN;
    end else if (op == `BSR_OP_IDCODE) begin
      sel = bsr_pkg::BSR_SEL_IDENT;
    end
    return sel;
  endfunction : dr_select

  function automatic logic drives_pins(input logic [`BSR_IR_W-1:0] op);
    return (op == `BSR_OP_EXTEST) || (op == `BSR_OP_CLAMP);
  endfunction : drives_pins

  bsr_pkg::bsr_dr_sel_t sel;
  logic extest;
  logic highz;
  logic pin_ctl;

  assign sel = dr_select(ir_current);
  assign extest = (ir_current == `BSR_OP_EXTEST);
  assign highz = (ir_current == `BSR_OP_HIGHZ);
  assign pin_ctl = drives_pins(ir_current);

  // ==========================================================
  // Pin and core signals crossing into the test clock domain
  // Each bit is sampled on its own, so a group changing just before
  // Capture-DR may be caught half old and half new: hold pins still first
  bsr_sync_if #(.W(SYN_W)) tck_sync_if ();

  assign tck_sync_if.async_d = {pad_bidir_in, core_bidir_out, core_bidir_oe,
                                core_tx, strap_pad, port_rx_pad};

  bsr_sync #(.W(SYN_W)) u_tck_sync (
    .clk(tck),
    .port(tck_sync_if.syn)
  );

  logic [RX_W-1:0] s_rx;
  logic [STRAP_W-1:0] s_strap;
  logic [TX_W-1:0] s_core_tx;
  logic [BI_W-1:0] s_core_oe;
  logic [BI_W-1:0] s_core_out;
  logic [BI_W-1:0] s_pad_in;

  assign {s_pad_in, s_core_out, s_core_oe, s_core_tx, s_strap, s_rx} = tck_sync_if.sync_q;

  // ==========================================================
  // Test clock state: rising edge shift stages, falling edge latches
  typedef struct packed {
    logic [CH_W-1:0] chain;
    logic byp;
    logic [`BSR_ID_W-1:0] ident;
  } bsr_rise_t;

  typedef struct packed {
    logic [UPD_W-1:0] upd;
    logic tdo;
    logic tdo_oe;
  } bsr_fall_t;

  bsr_rise_t r_q;
  bsr_rise_t r_d;
  bsr_fall_t f_q;
  bsr_fall_t f_d;

  logic [TX_W-1:0] upd_tx;
  logic [BI_W-1:0] upd_oe;
  logic [BI_W-1:0] upd_dat;

  assign upd_tx = f_q.upd[TX_LO-OBS_W +: TX_W];
  assign upd_oe = f_q.upd[OE_LO-OBS_W +: BI_W];
  assign upd_dat = f_q.upd[DAT_LO-OBS_W +: BI_W];

  // ==========================================================
  // Capture sources
  logic [BI_W-1:0] cap_oe;
  logic [BI_W-1:0] cap_dat;
  logic [CH_W-1:0] cap_vec;

  genvar gi;
  generate
    for (gi = 0; gi < BI_W; gi++) begin : g_bidir_cap
      // Enable cell value as it stands now, latched or functional
      assign cap_oe[gi] = pin_ctl ? upd_oe[gi] : s_core_oe[gi];
      // Single register per pin; source picked by the enable cell, always the pad under external-test
      assign cap_dat[gi] = (!extest && cap_oe[gi]) ? s_core_out[gi]
                                                   : s_pad_in[gi];
    end
  endgenerate

  // Chain order from the test output: receive, strap, transmit, enable, data
  generate
    for (gi = 0; gi < RX_W; gi++) begin : g_rx_cap
      assign cap_vec[gi] = s_rx[gi];
    end
    for (gi = 0; gi < STRAP_W; gi++) begin : g_strap_cap
      assign cap_vec[RX_W + gi] = s_strap[gi];
    end
    for (gi = 0; gi < TX_W; gi++) begin : g_tx_cap
      assign cap_vec[TX_LO + gi] = s_core_tx[gi];
    end
    for (gi = 0; gi < BI_W; gi++) begin : g_bidir_chain
      // Two cells per pin and no more, which keeps the chain short
      assign cap_vec[OE_LO + gi] = cap_oe[gi];
      assign cap_vec[DAT_LO + gi] = cap_dat[gi];
    end
  endgenerate

  // ==========================================================
  // Rising edge: capture and shift of the selected register
  // Pin samples are two test clocks old when Capture-DR takes them
  always_comb begin
    r_d = r_q;
    if (capture_dr) begin
      unique case (sel)
        bsr_pkg::BSR_SEL_CHAIN: r_d.chain = cap_vec;
        bsr_pkg::BSR_SEL_IDENT: r_d.ident = ID_CODE;
        bsr_pkg::BSR_SEL_BYPASS: r_d.byp = `BSR_BYPASS_CAPTURE;
      endcase
    end else if (shift_dr) begin
      unique case (sel)
        bsr_pkg::BSR_SEL_CHAIN: r_d.chain = {tdi, r_q.chain[CH_W-1:1]};
        bsr_pkg::BSR_SEL_IDENT: r_d.ident = {tdi, r_q.ident[`BSR_ID_W-1:1]};
        bsr_pkg::BSR_SEL_BYPASS: r_d.byp = tdi;
      endcase
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      r_q.chain <= '0;
      r_q.byp <= `BSR_BYPASS_RESET;
      r_q.ident <= ID_CODE;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Falling edge: output latches and test output
  logic serial_src;

  // Falling edge output gives the next device a full half period of hold
  always_comb begin
    serial_src = r_q.byp;
    unique case (sel)
      bsr_pkg::BSR_SEL_CHAIN: serial_src = r_q.chain[0];
      bsr_pkg::BSR_SEL_IDENT: serial_src = r_q.ident[0];
      bsr_pkg::BSR_SEL_BYPASS: serial_src = r_q.byp;
    endcase
  end

  always_comb begin
    f_d = f_q;
    // Latches move only in Update-DR, so shifting never disturbs the pins
    if (update_dr && sel == bsr_pkg::BSR_SEL_CHAIN) begin
      f_d.upd = r_q.chain[CH_W-1:OBS_W];
    end
    f_d.tdo = shift_ir ? ir_serial_out : serial_src;
    f_d.tdo_oe = shift_ir || shift_dr;
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      f_q.upd <= '0;
      f_q.tdo <= `BSR_TDO_RESET;
      f_q.tdo_oe <= 1'h0;
    end else begin
      f_q <= f_d;
    end
  end

  assign tdo = f_q.tdo;
  assign tdo_oe = f_q.tdo_oe;

  // ==========================================================
  // Observe cells: input-only pins pass straight to the core
  generate
    for (gi = 0; gi < RX_W; gi++) begin : g_rx_obs
      assign core_rx[gi] = port_rx_pad[gi];
    end
    for (gi = 0; gi < STRAP_W; gi++) begin : g_strap_obs
      assign core_strap[gi] = strap_pad[gi];
    end
  endgenerate

  // ==========================================================
  // Control cells on transmit pins; the latches take over as soon as
  // the instruction is current, with no clock edge in between
  generate
    for (gi = 0; gi < TX_W; gi++) begin : g_tx_ctl
      assign port_tx_pad[gi] = pin_ctl ? upd_tx[gi] : core_tx[gi];
      // No enable cell on these pins: only the all-off mode turns them off
      assign port_tx_oe[gi] = !highz;
    end
  endgenerate

  // ==========================================================
  // Bidirectional pins: enable cell and data cell side by side
  generate
    for (gi = 0; gi < BI_W; gi++) begin : g_bidir_pad
      logic drive_en;
      assign drive_en = pin_ctl ? upd_oe[gi] : core_bidir_oe[gi];
      assign pad_bidir_oe[gi] = !highz && drive_en;
      assign pad_bidir_out[gi] = pin_ctl ? upd_dat[gi] : core_bidir_out[gi];
      // The core always sees the pad level, even while the chain drives it
      assign core_bidir_in[gi] = pad_bidir_in[gi];
    end
  endgenerate

  // ==========================================================
  // Test mode status handed to the core clock domain
  // Each mode bit is a level of its own; a change of instruction may show
  // a mixed word for one core clock before it settles
  bsr_sync_if #(.W(`BSR_MODE_W)) core_sync_if ();

  assign core_sync_if.async_d = {highz, ir_current == `BSR_OP_CLAMP, extest};

  bsr_sync #(.W(`BSR_MODE_W)) u_core_sync (
    .clk(core_clk),
    .port(core_sync_if.syn)
  );

  typedef struct packed {
    logic [`BSR_MODE_W-1:0] mode;
  } bsr_core_t;

  bsr_core_t c_q;
  bsr_core_t c_d;

  always_comb begin
    c_d = c_q;
    c_d.mode = core_sync_if.sync_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      c_q.mode <= `BSR_MODE_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  assign core_test_mode = c_q.mode;

endmodule : bsr_top

// ### testbench/bsr_top_props.sv
`timescale 1ns/1ps
`include "bsr_defines.svh"
// ==========================================================
// Port checker; pads are combinational, so sampling them on tck is safe
module bsr_top_props #(
  parameter int RX_W = 64,
  parameter int TX_W = 32,
  parameter int BI_W = 20
) (
  // Clocks and resets
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic trst_n,
  // Test port
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic shift_ir,
  input wire logic [`BSR_IR_W-1:0] ir_current,
  // Pins
  input wire logic [RX_W-1:0] port_rx_pad,
  input wire logic [RX_W-1:0] core_rx,
  input wire logic [TX_W-1:0] core_tx,
  input wire logic [TX_W-1:0] port_tx_pad,
  input wire logic [BI_W-1:0] core_bidir_out,
  input wire logic [BI_W-1:0] core_bidir_oe,
  input wire logic [BI_W-1:0] core_bidir_in,
  input wire logic [BI_W-1:0] pad_bidir_in,
  input wire logic [BI_W-1:0] pad_bidir_out,
  input wire logic [BI_W-1:0] pad_bidir_oe,
  input wire logic [`BSR_MODE_W-1:0] core_test_mode
);
  logic ext;
  logic clp;
  logic hiz;
  logic byp;
  assign ext = ir_current == `BSR_OP_EXTEST;
  assign clp = ir_current == `BSR_OP_CLAMP;
  assign hiz = ir_current == `BSR_OP_HIGHZ;
  assign byp = ir_current == `BSR_OP_BYPASS;

  a_tdo_enable: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe == (shift_dr || shift_ir)) else $error("tdo enable wrong");
  a_bypass_path: assert property (@(posedge tck) disable iff (!trst_n)
    byp && shift_dr |=> tdo == $past(tdi)) else $error("bypass shift wrong");
  a_bypass_capture: assert property (@(posedge tck) disable iff (!trst_n)
    byp && capture_dr |=> !tdo) else $error("bypass capture wrong");
  // Latches move on the falling edge inside Update-DR, seen high at the next rise
  a_extest_hold: assert property (@(posedge tck) disable iff (!trst_n)
    ext && $past(ext) && !update_dr |-> $stable(port_tx_pad) && $stable(pad_bidir_out))
    else $error("extest outputs moved");
  a_normal_tx: assert property (@(posedge tck) disable iff (!trst_n)
    !ext && !clp && !hiz |-> port_tx_pad == core_tx) else $error("tx path altered");
  a_normal_bidir: assert property (@(posedge tck) disable iff (!trst_n)
    !ext && !clp && !hiz |-> pad_bidir_out == core_bidir_out && pad_bidir_oe == core_bidir_oe)
    else $error("bidir path altered");
  a_observe_only: assert property (@(posedge tck) disable iff (!trst_n)
    core_rx == port_rx_pad && core_bidir_in == pad_bidir_in) else $error("input path altered");
  a_highz_off: assert property (@(posedge tck) disable iff (!trst_n)
    hiz |-> pad_bidir_oe == '0) else $error("highz enables on");
  a_mode_extest: assert property (@(posedge core_clk) disable iff (reset)
    ext [*5] |-> core_test_mode == 3'h1) else $error("core mode wrong");

  c_bypass: cover property (@(posedge tck) byp && shift_dr);
  c_ext_update: cover property (@(posedge tck) ext && update_dr);
  c_highz: cover property (@(posedge tck) hiz);
endmodule : bsr_top_props

bind bsr_top bsr_top_props #(.RX_W(RX_W), .TX_W(TX_W), .BI_W(BI_W)) u_bsr_top_props (.*);

// ### testbench/bsr_tester.sv
`timescale 1ns/1ps
`include "bsr_defines.svh"
// ==========================================================
// Board tester model
module bsr_tester (
  // Toward the device
  output logic tck,
  output logic trst_n,
  output logic tdi,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  output logic [`BSR_IR_W-1:0] ir_current,
  // From the device
  input wire logic tdo
);
  // Clock runs in idle too, so the pin samplers keep settling
  initial begin
    {tck, trst_n, capture_dr, shift_dr, update_dr} = '0;
    tdi = 1'h1;
    ir_current = `BSR_OP_BYPASS;
    #3;
    forever #7.5 tck = ~tck;
  end
  initial begin
    repeat (3) @(posedge tck);
    trst_n <= 1'h1;
  end
  // Changes land after a rising edge so the next rising edge samples them
  task automatic set_ir(input logic [`BSR_IR_W-1:0] ir);
    @(posedge tck);
    ir_current <= ir;
    @(posedge tck);
  endtask : set_ir
  task automatic scan(input logic [`BSR_IR_W-1:0] ir, input logic [153:0] din,
      input int n, output logic [153:0] dout);
    dout = '0;
    set_ir(ir);
    capture_dr <= 1'h1;
    @(posedge tck);
    capture_dr <= 1'h0;
    shift_dr <= 1'h1;
    tdi <= din[0];
    for (int k = 0; k < n; k++) begin
      @(posedge tck);
      dout[k] = tdo;
      din = din >> 1;
      tdi <= din[0];
    end
    shift_dr <= 1'h0;
    tdi <= 1'h1;
    update_dr <= 1'h1;
    @(posedge tck);
    update_dr <= 1'h0;
  endtask : scan
endmodule : bsr_tester

// ### testbench/bsr_top_tb_top.sv
`timescale 1ns/1ps
`include "bsr_defines.svh"
`define BSR_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module bsr_top_tb_top;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic tck, trst_n, tdi, tdo, tdo_oe, capture_dr, shift_dr, update_dr;
  logic shift_ir = 1'h0;
  logic ir_serial_out = 1'h0;
  logic [5:0] ir_current;
  logic [63:0] port_rx_pad = 64'hDEADBEEF01234567;
  logic [63:0] core_rx;
  logic [17:0] strap_pad = 18'h2A5C3;
  logic [17:0] core_strap;
  logic [31:0] core_tx = 32'hC0FFEE11;
  logic [31:0] port_tx_pad, port_tx_oe;
  logic [19:0] core_bidir_out = 20'h12345;
  logic [19:0] core_bidir_oe = 20'hAAAAA;
  logic [19:0] ext = 20'hFEDCB;
  logic [19:0] core_bidir_in, pad_bidir_out, pad_bidir_oe;
  wire logic [19:0] pad_bidir_in;
  logic [2:0] core_test_mode;
  logic [153:0] d;
  int n_errors = 0;
  int n_compared = 0;
  localparam logic [153:0] PV = {20'h3C5A1, 20'hF0F0F, 32'hA5C30F96, 82'h0};
  localparam logic [153:0] PV2 = {20'h0F00F, 20'h33CC3, 32'h5A3CF069, 82'h0};
  // Board wire: the pad wins when enabled, otherwise the far driver
  assign pad_bidir_in = (pad_bidir_oe & pad_bidir_out) | (~pad_bidir_oe & ext);
  always #12.5 core_clk = ~core_clk;
  bsr_top u_bsr_top (.*);
  bsr_tester u_bsr_tester (.*);

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic t_bypass;
    u_bsr_tester.scan(`BSR_OP_BYPASS, 154'h2D, 8, d);
    `BSR_CHK("bypass", 8'h5A, d[7:0])
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_ident;
    u_bsr_tester.scan(`BSR_OP_IDCODE, 154'h0, 32, d);
    `BSR_CHK("ident", `BSR_ID_DEFAULT, d[31:0])
    $display("test ident done");
  endtask : t_ident
  task automatic t_sample;
    @(posedge core_clk);
    core_bidir_oe <= 20'h5AA5A;
    repeat (4) @(posedge tck);
    u_bsr_tester.scan(`BSR_OP_SAMPLE, PV, 154, d);
    `BSR_CHK("rx", port_rx_pad, d[63:0])
    `BSR_CHK("strap", strap_pad, d[81:64])
    `BSR_CHK("tx", core_tx, d[113:82])
    `BSR_CHK("oecell", core_bidir_oe, d[133:114])
    `BSR_CHK("bi", (core_bidir_out & core_bidir_oe) | (ext & ~core_bidir_oe), d[153:134])
    `BSR_CHK("txpad", core_tx, port_tx_pad)
    `BSR_CHK("txoe", 32'hFFFFFFFF, port_tx_oe)
    `BSR_CHK("corestrap", strap_pad, core_strap)
    $display("test sample done");
  endtask : t_sample
  task automatic t_extest;
    u_bsr_tester.set_ir(`BSR_OP_EXTEST);
    `BSR_CHK("txpad", PV[113:82], port_tx_pad)
    `BSR_CHK("bioe", PV[133:114], pad_bidir_oe)
    `BSR_CHK("biout", PV[153:134], pad_bidir_out)
    repeat (6) @(posedge core_clk);
    `BSR_CHK("mode", 3'h1, core_test_mode)
    u_bsr_tester.scan(`BSR_OP_EXTEST, PV2, 154, d);
    `BSR_CHK("bi", (PV[153:134] & PV[133:114]) | (ext & ~PV[133:114]), d[153:134])
    `BSR_CHK("txpad", PV2[113:82], port_tx_pad)
    u_bsr_tester.set_ir(`BSR_OP_HIGHZ);
    `BSR_CHK("hiz", 20'h0, pad_bidir_oe)
    `BSR_CHK("hiztx", 32'h0, port_tx_oe)
    u_bsr_tester.set_ir(`BSR_OP_BYPASS);
    $display("test extest done");
  endtask : t_extest

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'h0;
    repeat (8) @(posedge tck);
    t_bypass;
    t_ident;
    t_sample;
    t_extest;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    stop_test;
  end
endmodule : bsr_top_tb_top
